// ### rtl/diq_cond.sv
// Force and polarity stage for the physical inputs.
// Assumes registered raw levels and mask registers from the top.
`timescale 1ns/1ps
module diq_cond
  import diq_pkg::*;
(
  // Levels and masks.
  input  wire logic [DIQ_NUM_IN-1:0] raw_i,
  input  wire logic [DIQ_NUM_IN-1:0] force_en_i,
  input  wire logic [DIQ_NUM_IN-1:0] force_val_i,
  input  wire logic [DIQ_NUM_IN-1:0] invert_i,
  input  wire logic [DIQ_NUM_IN-1:0] clkdir_i,
  // Conditioned levels.
  output logic      [DIQ_NUM_IN-1:0] cond_o
);

  logic [DIQ_NUM_IN-1:0] forced;

  // Forcing comes first, so a forced value is itself subject to inversion.
  assign forced = (force_en_i & force_val_i) |
                  (~force_en_i & raw_i);
  // Clock and direction inputs keep their polarity whatever the mask holds.
  assign cond_o = forced ^ (invert_i & ~clkdir_i);

endmodule // diq_cond

// ### rtl/diq_pkg.sv
// Constants, object map and carrier types of the digital input conditioning.
// Assumes a single 40 MHz clock domain and the object access port of the top.
package diq_pkg;

  // Object indices and subindices of the control and routing objects.
  localparam logic [15:0] DIQ_IDX_CTRL  = 16'h3240;
  localparam logic [15:0] DIQ_IDX_ROUTE = 16'h3242;
  localparam logic [7:0]  DIQ_SUB_COUNT = 8'h00;
  localparam logic [7:0]  DIQ_SUB_SFE   = 8'h01;
  localparam logic [7:0]  DIQ_SUB_INV   = 8'h02;
  localparam logic [7:0]  DIQ_SUB_FEN   = 8'h03;
  localparam logic [7:0]  DIQ_SUB_FVAL  = 8'h04;
  localparam logic [7:0]  DIQ_SUB_RAW   = 8'h05;
  localparam logic [7:0]  DIQ_SUB_THR   = 8'h06;
  localparam logic [7:0]  DIQ_SUB_DIFF  = 8'h07;
  localparam logic [7:0]  DIQ_SUB_RTEN  = 8'h08;
  localparam logic [7:0]  DIQ_SUB_SEL1  = 8'h01;

  // Entry counts and reset values.
  localparam logic [7:0]  DIQ_CTRL_ENTRIES  = 8'h08;
  localparam logic [7:0]  DIQ_ROUTE_ENTRIES = 8'h24;
  localparam logic [31:0] DIQ_MASK_RESET    = 32'h0000_0000;
  localparam logic [7:0]  DIQ_SEL_RESET     = 8'h00;
  localparam logic [31:0] DIQ_RTEN_ON       = 32'h0000_0001;

  // Sizes.
  localparam int DIQ_NUM_IN  = 16;
  localparam int DIQ_NUM_SEL = 36;

  // Special function bit positions.
  localparam int DIQ_BIT_NEG_LIM = 0;
  localparam int DIQ_BIT_POS_LIM = 1;
  localparam int DIQ_BIT_HOME    = 2;
  localparam int DIQ_BIT_ILOCK   = 3;
  localparam int DIQ_STAT_IN_LSB = 16;

  // Source selector codes.
  localparam logic [6:0] DIQ_SRC_ZERO    = 7'h00;
  localparam logic [6:0] DIQ_SRC_PHYS_LO = 7'h01;
  localparam logic [6:0] DIQ_SRC_PHYS_HI = 7'h10;
  localparam logic [6:0] DIQ_SRC_HALL_U  = 7'h41;
  localparam logic [6:0] DIQ_SRC_HALL_V  = 7'h42;
  localparam logic [6:0] DIQ_SRC_HALL_W  = 7'h43;
  localparam logic [6:0] DIQ_SRC_ENC_A   = 7'h44;
  localparam logic [6:0] DIQ_SRC_ENC_B   = 7'h45;
  localparam logic [6:0] DIQ_SRC_ENC_I   = 7'h46;
  localparam logic [6:0] DIQ_SRC_ETH     = 7'h48;
  localparam int         DIQ_SEL_INV_BIT = 7;

  // Input pins as seen at the block boundary.
  typedef struct packed {
    logic                  eth_active;
    logic [2:0]            enc;
    logic [2:0]            hall;
    logic [DIQ_NUM_IN-1:0] phys;
  } diq_pins_t;

  // One object access request.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } diq_req_t;

endpackage : diq_pkg

// ### rtl/diq_src_mux.sv
// One routing selector: decodes a source code into one status bit.
// Assumes conditioned input levels and synchronous auxiliary pins.
`timescale 1ns/1ps
module diq_src_mux
  import diq_pkg::*;
(
  // Selector code and candidate sources.
  input  wire logic [7:0]            code_i,
  input  wire logic [DIQ_NUM_IN-1:0] cond_i,
  input  wire diq_pins_t             pins_i,
  // Selected bit.
  output logic                       bit_o
);

  logic base;
  logic known;

  // Unlisted codes give a steady zero rather than an arbitrary pin.
  always_comb begin
    base  = 1'b0;
    known = 1'b1;
    if (code_i[6:0] == DIQ_SRC_ZERO) begin
      base = 1'b0;
    end else if (code_i[6:0] >= DIQ_SRC_PHYS_LO &&
                 code_i[6:0] <= DIQ_SRC_PHYS_HI) begin
      base = cond_i[4'(code_i[6:0] - DIQ_SRC_PHYS_LO)];
    end else begin
      unique case (code_i[6:0])
        DIQ_SRC_HALL_U: base = pins_i.hall[0];
        DIQ_SRC_HALL_V: base = pins_i.hall[1];
        DIQ_SRC_HALL_W: base = pins_i.hall[2];
        DIQ_SRC_ENC_A:  base = pins_i.enc[0];
        DIQ_SRC_ENC_B:  base = pins_i.enc[1];
        DIQ_SRC_ENC_I:  base = pins_i.enc[2];
        DIQ_SRC_ETH:    base = pins_i.eth_active;
        default:        known = 1'b0;
      endcase
    end
  end

  // Bit 7 inverts, so code 80 hex yields a constant one.
  assign bit_o = known & (base ^ code_i[DIQ_SEL_INV_BIT]);

endmodule // diq_src_mux

// ### rtl/diq_top.sv
// Digital input conditioning: masks, forcing, inversion and routing that
// build the input status word, with an object access port for settings.
// Assumes all pins and requests are synchronous to clk_i.
//
// Contract
// - Special function enable bit 0 disables, 1 allows that input's function.
// - Special function enables never touch status bits 16 to 31.
// - Enable bits 0..3 mean negative limit, positive limit, home, interlock.
// - Invert bit 0 passes high as 1; invert bit 1 turns high into 0.
// - Inversion covers special and ordinary inputs, never clock/direction inputs.
// - Mask bit n controls physical input n+1.
// - Force enable 1 replaces the pin value with a simulated one.
// - A forced input takes its bit from the force value mask.
// - Raw value shows unmodified pin levels.
// - Threshold bit 0 selects 5 V, bit 1 selects 24 V.
// - Differential bit 0 selects single-ended, 1 selects differential.
// - Routing enable value 1 builds the status word through the table.
// - Routing decides the source of every status bit.
// - Thirty-six byte-wide read/write selectors, all resetting to zero.
// - Selector k sources status bit k-1.
// - Codes: 00 zero, 01-10 inputs, 80 one, bit 7 inverts.
`timescale 1ns/1ps
module diq_top
  import diq_pkg::*;
(
  // Clock and reset.
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Input pins and clock/direction marking.
  input  wire diq_pins_t             pins_i,
  input  wire logic [DIQ_NUM_IN-1:0] clkdir_i,
  // Object access port.
  input  wire diq_req_t              req_i,
  output logic [31:0]                rdata_o,
  output logic                       ack_o,
  output logic                       err_o,
  // Conditioned results.
  output logic [31:0]                input_status_word_o,
  output logic [3:0]                 routed_extra_o,
  output logic                       neg_limit_o,
  output logic                       pos_limit_o,
  output logic                       home_o,
  output logic                       interlock_o,
  // Analog front-end selects.
  output logic [DIQ_NUM_IN-1:0]      thr_24v_o,
  output logic [DIQ_NUM_IN-1:0]      diff_sel_o
);

  // Settings.
  logic [31:0] sfe_q;
  logic [31:0] inv_q;
  logic [31:0] fen_q;
  logic [31:0] fval_q;
  logic [31:0] thr_q;
  logic [31:0] diff_q;
  logic [31:0] rten_q;
  logic [7:0]  sel_q [DIQ_NUM_SEL];

  // Captured pins and derived levels.
  diq_pins_t              pins_q;
  logic [DIQ_NUM_IN-1:0]  cond;
  logic [DIQ_NUM_SEL-1:0] routed;
  logic [31:0]            direct;
  logic [31:0]            status_d;

  // Access decode.
  logic        hit_ctrl;
  logic        hit_route;
  logic        sel_hit;
  logic [5:0]  sel_idx;
  logic        bad_d;
  logic [31:0] rdata_d;

  // True when a subindex addresses one of the routing selectors.
  function automatic logic is_sel_sub(input logic [7:0] sub);
    return sub >= DIQ_SUB_SEL1 && sub <= DIQ_ROUTE_ENTRIES;
  endfunction

  // True when this request writes the given control subindex.
  function automatic logic ctrl_wr(input diq_req_t r, input logic [7:0] sub);
    return r.wr && r.index == DIQ_IDX_CTRL && r.sub == sub;
  endfunction

  assign hit_ctrl  = req_i.index == DIQ_IDX_CTRL;
  assign hit_route = req_i.index == DIQ_IDX_ROUTE;
  assign sel_hit   = hit_route && is_sel_sub(req_i.sub);
  assign sel_idx   = 6'(req_i.sub - DIQ_SUB_SEL1);

  // Pins are registered once so status and raw value share one sample.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pins_q <= '0;
    end else begin
      pins_q <= pins_i;
    end
  end

  // Control object writes, one register each. The raw value subindex has
  // no register: a write to it is answered and dropped.

  // Special function enables; bits above the four decoded ones are kept
  // only so that software reads back what it wrote.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sfe_q <= DIQ_MASK_RESET;
    end else if (ctrl_wr(req_i, DIQ_SUB_SFE)) begin
      sfe_q <= req_i.wdata;
    end
  end

  // Polarity mask. It acts after forcing, so a forced level is inverted
  // as well, which keeps simulated and real switches alike.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      inv_q <= DIQ_MASK_RESET;
    end else if (ctrl_wr(req_i, DIQ_SUB_INV)) begin
      inv_q <= req_i.wdata;
    end
  end

  // Force enables. A set bit cuts the pin off from everything downstream
  // except the raw value, which keeps showing the real level.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fen_q <= DIQ_MASK_RESET;
    end else if (ctrl_wr(req_i, DIQ_SUB_FEN)) begin
      fen_q <= req_i.wdata;
    end
  end

  // Force values only matter where the force enable is set, so writing
  // them before the enables avoids a one-cycle glitch on the status word.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fval_q <= DIQ_MASK_RESET;
    end else if (ctrl_wr(req_i, DIQ_SUB_FVAL)) begin
      fval_q <= req_i.wdata;
    end
  end

  // Threshold selects; only the low half has inputs behind it, the upper
  // half is kept for read-back.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      thr_q <= DIQ_MASK_RESET;
    end else if (ctrl_wr(req_i, DIQ_SUB_THR)) begin
      thr_q <= req_i.wdata;
    end
  end

  // Differential selects; inputs without a differential receiver simply
  // ignore their bit.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      diff_q <= DIQ_MASK_RESET;
    end else if (ctrl_wr(req_i, DIQ_SUB_DIFF)) begin
      diff_q <= req_i.wdata;
    end
  end

  // Routing enable. Only the exact value one switches the table in, so a
  // stray write of another value cannot redirect the limit inputs.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rten_q <= DIQ_MASK_RESET;
    end else if (ctrl_wr(req_i, DIQ_SUB_RTEN)) begin
      rten_q <= req_i.wdata;
    end
  end

  // Routing selector writes take the low byte of the write data.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < DIQ_NUM_SEL; i++) begin
        sel_q[i] <= DIQ_SEL_RESET;
      end
    end else if (req_i.wr && sel_hit) begin
      sel_q[sel_idx] <= req_i.wdata[7:0];
    end
  end

  // Read data and error decode for the access port.
  always_comb begin
    rdata_d = 32'h0000_0000;
    bad_d   = 1'b0;
    if (hit_ctrl) begin
      unique case (req_i.sub)
        DIQ_SUB_COUNT: begin
          rdata_d = {24'h00_0000, DIQ_CTRL_ENTRIES};
          bad_d   = req_i.wr;
        end
        DIQ_SUB_SFE:  rdata_d = sfe_q;
        DIQ_SUB_INV:  rdata_d = inv_q;
        DIQ_SUB_FEN:  rdata_d = fen_q;
        DIQ_SUB_FVAL: rdata_d = fval_q;
        DIQ_SUB_RAW:  rdata_d = {16'h0000, pins_q.phys};
        DIQ_SUB_THR:  rdata_d = thr_q;
        DIQ_SUB_DIFF: rdata_d = diff_q;
        DIQ_SUB_RTEN: rdata_d = rten_q;
        default:      bad_d   = 1'b1;
      endcase
    end else if (hit_route) begin
      if (req_i.sub == DIQ_SUB_COUNT) begin
        rdata_d = {24'h00_0000, DIQ_ROUTE_ENTRIES};
        bad_d   = req_i.wr;
      end else if (sel_hit) begin
        rdata_d = {24'h00_0000, sel_q[sel_idx]};
      end else begin
        bad_d = 1'b1;
      end
    end else begin
      bad_d = 1'b1;
    end
  end

  // Every request is answered one cycle later, good or bad.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0000_0000;
      ack_o   <= 1'b0;
      err_o   <= 1'b0;
    end else begin
      ack_o   <= req_i.rd | req_i.wr;
      err_o   <= (req_i.rd | req_i.wr) & bad_d;
      rdata_o <= req_i.rd ? rdata_d : 32'h0000_0000;
    end
  end

  // Force and polarity on the physical inputs.
  diq_cond u_cond (
    .raw_i       (pins_q.phys),
    .force_en_i  (fen_q[DIQ_NUM_IN-1:0]),
    .force_val_i (fval_q[DIQ_NUM_IN-1:0]),
    .invert_i    (inv_q[DIQ_NUM_IN-1:0]),
    .clkdir_i    (clkdir_i),
    .cond_o      (cond)
  );

  // One source decoder per selector.
  for (genvar k = 0; k < DIQ_NUM_SEL; k++) begin : g_route
    diq_src_mux u_mux (
      .code_i (sel_q[k]),
      .cond_i (cond),
      .pins_i (pins_q),
      .bit_o  (routed[k])
    );
  end

  // Direct mapping: gated special functions low, plain inputs high.
  always_comb begin
    direct = 32'h0000_0000;
    direct[DIQ_BIT_NEG_LIM] = cond[DIQ_BIT_NEG_LIM] & sfe_q[DIQ_BIT_NEG_LIM];
    direct[DIQ_BIT_POS_LIM] = cond[DIQ_BIT_POS_LIM] & sfe_q[DIQ_BIT_POS_LIM];
    direct[DIQ_BIT_HOME]    = cond[DIQ_BIT_HOME] & sfe_q[DIQ_BIT_HOME];
    direct[DIQ_BIT_ILOCK]   = cond[DIQ_BIT_ILOCK] & sfe_q[DIQ_BIT_ILOCK];
    // The upper half never looks at the enable mask.
    direct[31:DIQ_STAT_IN_LSB] = cond;
  end

  // Only the exact value one turns routing on; other values keep it off.
  assign status_d = (rten_q == DIQ_RTEN_ON) ? routed[31:0]
                                            : direct;

  // Status word and the routed bits beyond its 32 positions.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      input_status_word_o <= 32'h0000_0000;
      routed_extra_o      <= 4'h0;
    end else begin
      input_status_word_o <= status_d;
      routed_extra_o      <= routed[DIQ_NUM_SEL-1:32];
    end
  end

  // Special function levels use the enables whether routing is on or not,
  // so rerouting the status word never disarms a limit switch.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      neg_limit_o <= 1'b0;
      pos_limit_o <= 1'b0;
      home_o      <= 1'b0;
      interlock_o <= 1'b0;
    end else begin
      // Unwired sensors rely on software leaving their enables clear.
      neg_limit_o <= cond[DIQ_BIT_NEG_LIM] & sfe_q[DIQ_BIT_NEG_LIM];
      pos_limit_o <= cond[DIQ_BIT_POS_LIM] & sfe_q[DIQ_BIT_POS_LIM];
      home_o      <= cond[DIQ_BIT_HOME] & sfe_q[DIQ_BIT_HOME];
      interlock_o <= cond[DIQ_BIT_ILOCK] & sfe_q[DIQ_BIT_ILOCK];
    end
  end

  // Threshold selects reach the comparators one register after the write.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      thr_24v_o <= '0;
    end else begin
      thr_24v_o <= thr_q[DIQ_NUM_IN-1:0];
    end
  end

  // Differential selects, registered the same way so both move together.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      diff_sel_o <= '0;
    end else begin
      diff_sel_o <= diff_q[DIQ_NUM_IN-1:0];
    end
  end

endmodule // diq_top

// ### tb/diq_sw_model.sv
// Model of the switches and sensors wired to the inputs.
// Assumes the bench names wanted levels; lines move just after each edge.
`timescale 1ns/1ps
module diq_sw_model
  import diq_pkg::*;
(
  // Clock and wanted levels.
  input  wire logic      clk_i,
  input  wire diq_pins_t want_i,
  // Levels on the input lines.
  output diq_pins_t      pins_o
);
  // Lines start low and follow the wanted level a moment after each edge.
  initial pins_o = '0;
  always @(posedge clk_i) pins_o <= #1 want_i;
endmodule // diq_sw_model

// ### tb/diq_top_asserts.sv
// Checker for the conditioning top: object port answers and selects.
// Assumes it is bound onto diq_top and sees only that module's ports.
`timescale 1ns/1ps
module diq_top_asserts
  import diq_pkg::*;
(
  // Clock, reset and inputs.
  input wire logic            clk_i,
  input wire logic            rst_i,
  input wire diq_pins_t       pins_i,
  input wire diq_req_t        req_i,
  // Watched outputs.
  input wire logic [31:0]     rdata_o,
  input wire logic            ack_o,
  input wire logic            err_o,
  input wire logic [15:0]     thr_24v_o,
  input wire logic [15:0]     diff_sel_o,
  input wire logic            neg_limit_o,
  input wire logic            pos_limit_o,
  input wire logic            home_o,
  input wire logic            interlock_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Decoded request places; a bad place must never be answered cleanly.
  logic ctl, rte, bad;
  assign ctl = req_i.index == DIQ_IDX_CTRL;
  assign rte = req_i.index == DIQ_IDX_ROUTE;
  assign bad = (ctl && req_i.sub > 8'h08) || (rte && req_i.sub > 8'h24) ||
               (req_i.wr && req_i.sub == 8'h00 && (ctl || rte));

  // A setting write followed by a quiet cycle.
  sequence s_set(logic [7:0] s);
    req_i.wr && ctl && req_i.sub == s ##1 !req_i.wr;
  endsequence

  a_ack_follows_req: assert property (
    ack_o == $past(req_i.rd || req_i.wr))
    else $error("ack not one cycle after request");
  a_bad_place_err: assert property (
    (req_i.rd || req_i.wr) && bad |=> ack_o && err_o)
    else $error("bad place not refused");
  a_route_count_rd: assert property (
    req_i.rd && !req_i.wr && rte && req_i.sub == 8'h00
    |=> rdata_o == 32'h0000_0024 && !err_o)
    else $error("route count wrong");
  a_raw_read_pins: assert property (
    req_i.rd && !req_i.wr && ctl && req_i.sub == DIQ_SUB_RAW &&
    $stable(pins_i.phys) |=> rdata_o == {16'h0000, $past(pins_i.phys)})
    else $error("raw value not the pin levels");
  a_raw_write_ok: assert property (
    req_i.wr && ctl && req_i.sub == DIQ_SUB_RAW |=> ack_o && !err_o)
    else $error("raw write refused");
  a_thr_follows_wr: assert property (
    s_set(DIQ_SUB_THR) |=> thr_24v_o == $past(req_i.wdata[15:0], 2))
    else $error("threshold select stale");
  a_diff_follows_wr: assert property (
    s_set(DIQ_SUB_DIFF) |=> diff_sel_o == $past(req_i.wdata[15:0], 2))
    else $error("differential select stale");
  a_limits_gated_off: assert property (
    s_set(DIQ_SUB_SFE) |=> ({interlock_o, home_o, pos_limit_o, neg_limit_o} &
    ~$past(req_i.wdata[3:0], 2)) == 4'h0)
    else $error("disabled function active");
endmodule // diq_top_asserts

bind diq_top diq_top_asserts diq_top_asserts_i (.clk_i, .rst_i, .pins_i,
  .req_i, .rdata_o, .ack_o, .err_o, .thr_24v_o, .diff_sel_o, .neg_limit_o,
  .pos_limit_o, .home_o, .interlock_o);

// ### tb/tb_diq_top.sv
// Bench for the digital input conditioning top with a sensor model.
// Assumes the checker is bound in and everything runs on one clock.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module tb_diq_top;
  import diq_pkg::*;
  // Stimulus, observed outputs and counters.
  logic        clk_i, rst_i, ack, err, e_v;
  diq_pins_t   want, pins;
  diq_req_t    req;
  logic [15:0] clkdir, thr, dif;
  logic [31:0] rdata, stat, rd_v;
  logic [3:0]  extra, lim;
  int          failures, checked;

  diq_sw_model diq_sw_model_i (.clk_i(clk_i), .want_i(want), .pins_o(pins));
  diq_top diq_top_i (.clk_i(clk_i), .rst_i(rst_i), .pins_i(pins),
    .clkdir_i(clkdir), .req_i(req), .rdata_o(rdata), .ack_o(ack),
    .err_o(err), .input_status_word_o(stat), .routed_extra_o(extra),
    .neg_limit_o(lim[0]), .pos_limit_o(lim[1]), .home_o(lim[2]),
    .interlock_o(lim[3]), .thr_24v_o(thr), .diff_sel_o(dif));

  // The 40 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // One access; the request stands over its taking edge only.
  task automatic acc(input logic w, input logic [15:0] i,
                     input logic [7:0] s, input logic [31:0] d);
    @(posedge clk_i);
    #1 req = '{rd: !w, wr: w, index: i, sub: s, wdata: d};
    @(posedge clk_i);
    #1 req = '0;
    rd_v = rdata;
    e_v = err;
    `CHK(ack, 1'b1)
  endtask

  task automatic rchk(input logic [15:0] i, input logic [7:0] s,
                      input logic [31:0] x);
    acc(1'b0, i, s, 32'h0);
    `CHK({e_v, rd_v}, {1'b0, x})
  endtask

  // Three edges cover the pin register and the output register.
  task automatic settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  function automatic logic [31:0] dexp(logic [15:0] c, logic [3:0] en);
    return {c, 12'h000, c[3:0] & en};
  endfunction

  task automatic t_regs;
    logic [15:0] bi [5] = '{DIQ_IDX_CTRL, DIQ_IDX_ROUTE, DIQ_IDX_ROUTE,
                            DIQ_IDX_CTRL, 16'h3241};
    logic [7:0]  bs [5] = '{8'h00, 8'h00, 8'h25, 8'h09, 8'h01};
    rchk(DIQ_IDX_CTRL, 8'h00, 32'h0000_0008);
    rchk(DIQ_IDX_ROUTE, 8'h00, 32'h0000_0024);
    for (int k = 1; k <= 36; k++) begin
      rchk(DIQ_IDX_ROUTE, 8'(k), 32'h0);
      if (k <= 8) rchk(DIQ_IDX_CTRL, 8'(k), 32'h0);
      if (k <= 8 && k != 5) begin
        acc(1'b1, DIQ_IDX_CTRL, 8'(k), 32'ha5a5_5a5a);
        rchk(DIQ_IDX_CTRL, 8'(k), 32'ha5a5_5a5a);
        acc(1'b1, DIQ_IDX_CTRL, 8'(k), 32'h0);
      end
    end
    acc(1'b1, DIQ_IDX_ROUTE, 8'h24, 32'h0000_01c5);
    rchk(DIQ_IDX_ROUTE, 8'h24, 32'h0000_00c5);
    for (int k = 0; k < 5; k++) begin
      acc(k < 2, bi[k], bs[k], 32'h0000_00ff);
      `CHK(e_v, 1'b1)
    end
    acc(1'b1, DIQ_IDX_CTRL, DIQ_SUB_RAW, 32'hffff_ffff);
    `CHK(e_v, 1'b0)
    rchk(DIQ_IDX_CTRL, DIQ_SUB_RAW, 32'h0);
    $display("test regs ends");
  endtask

  task automatic t_direct;
    @(posedge clk_i);
    #1 want.phys = 16'h9e3d;
    acc(1'b1, DIQ_IDX_CTRL, DIQ_SUB_SFE, 32'hffff_000f);
    settle;
    `CHK(stat, dexp(16'h9e3d, 4'hf))
    `CHK(lim, 4'hd)
    // Positive limit and interlock are not wired, so they are cleared.
    acc(1'b1, DIQ_IDX_CTRL, DIQ_SUB_SFE, 32'h0000_0005);
    settle;
    `CHK(stat, dexp(16'h9e3d, 4'h5))
    `CHK(lim, 4'h5)
    rchk(DIQ_IDX_CTRL, DIQ_SUB_RAW, 32'h0000_9e3d);
    $display("test direct ends");
  endtask

  task automatic t_cond;
    logic [15:0] c;
    c = ((16'h9e3d & ~16'h0f00) | 16'h0a00) ^ (16'h0cf0 & ~16'h0030);
    clkdir = 16'h0030;
    acc(1'b1, DIQ_IDX_CTRL, DIQ_SUB_INV, 32'h0000_0cf0);
    acc(1'b1, DIQ_IDX_CTRL, DIQ_SUB_FEN, 32'h0000_0f00);
    acc(1'b1, DIQ_IDX_CTRL, DIQ_SUB_FVAL, 32'h0000_0a00);
    settle;
    `CHK(stat, dexp(c, 4'h5))
    rchk(DIQ_IDX_CTRL, DIQ_SUB_RAW, 32'h0000_9e3d);
    acc(1'b1, DIQ_IDX_CTRL, DIQ_SUB_INV, 32'h0);
    acc(1'b1, DIQ_IDX_CTRL, DIQ_SUB_FEN, 32'h0);
    clkdir = 16'h0000;
    $display("test cond ends");
  endtask

  task automatic t_route;
    logic [7:0] ks [12] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 33, 36};
    logic [7:0] cs [12] = '{8'h01, 8'h81, 8'h80, 8'h00, 8'h41, 8'hc4,
                            8'h48, 8'h10, 8'h45, 8'h8f, 8'h80, 8'h90};
    want.hall = 3'b111;
    want.eth_active = 1'b1;
    for (int k = 0; k < 12; k++) acc(1'b1, DIQ_IDX_ROUTE, ks[k], {24'h0, cs[k]});
    acc(1'b1, DIQ_IDX_CTRL, DIQ_SUB_RTEN, DIQ_RTEN_ON);
    settle;
    `CHK(stat, 32'h0000_02f5)
    `CHK(extra, 4'h1)
    acc(1'b1, DIQ_IDX_CTRL, DIQ_SUB_RTEN, 32'h0000_0002);
    settle;
    `CHK(stat, dexp(16'h9e3d, 4'h5))
    $display("test route ends");
  endtask

  task automatic t_front;
    acc(1'b1, DIQ_IDX_CTRL, DIQ_SUB_THR, 32'h0001_8421);
    acc(1'b1, DIQ_IDX_CTRL, DIQ_SUB_DIFF, 32'h0000_4812);
    settle;
    `CHK({thr, dif}, {16'h8421, 16'h4812})
    $display("test front ends");
  endtask

  task automatic print_verdict;
    $display("checked %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence, released a moment after the twentieth edge.
  initial begin
    rst_i    = 1'b1;
    want     = '0;
    clkdir   = '0;
    req      = '0;
    failures = 0;
    checked  = 0;
    repeat (20) @(posedge clk_i);
    #1 rst_i = 1'b0;
    t_regs;
    t_direct;
    t_cond;
    t_route;
    t_front;
    print_verdict;
  end

  // Watchdog well beyond the hundred or so accesses of the run.
  initial begin
    repeat (8000) @(posedge clk_i);
    failures++;
    print_verdict;
  end
endmodule // tb_diq_top
